/* File: msfr_regs.sv */
// Monitor instance selector, bandwidth filter and storage usage value registers
`timescale 1ns/1ps
`include "msfr_cfg.svh"

module msfr_regs (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Presence flags from the identification registers
   input wire logic monitors_present_i,
   input wire logic bandwidth_usage_present_i,
   input wire logic storage_usage_present_i,
   input wire logic impl_identification_present_i,
   // Register access port
   input wire logic reg_req_i,
   input wire logic reg_wr_i,
   input wire logic reg_ns_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic reg_ack_o,
   output logic [31:0] reg_rdata_o,
   output logic reg_oob_err_o,
   // Bandwidth control registers, one per state and instance, [ns*N + idx]
   input wire logic [31:0] bw_ctl_i [0:2*`MSFR_NUM_INST-1],
   // Traffic labels seen by the bandwidth datapath
   input wire logic traffic_valid_i,
   input wire logic traffic_ns_i,
   input wire msfr_pkg::msfr_part_t traffic_partition_i,
   input wire msfr_pkg::msfr_group_t traffic_group_i,
   output logic [2*`MSFR_NUM_INST-1:0] bw_count_en_o,
   // Storage usage updates from the occupancy datapath
   input wire logic su_upd_i,
   input wire logic su_upd_ns_i,
   input wire logic [`MSFR_IDX_W-1:0] su_upd_idx_i,
   input wire logic su_upd_not_ready_i,
   input wire logic [30:0] su_upd_bytes_i,
   // Selected instance per state for the other monitor register blocks
   output msfr_pkg::msfr_index_t sel_s_o,
   output msfr_pkg::msfr_index_t sel_ns_o
);

   localparam int NI = `MSFR_NUM_INST;

   // ----------------------------------------
   // State
   // ----------------------------------------
   msfr_pkg::msfr_index_t sel_s;
   msfr_pkg::msfr_index_t sel_ns;
   // Filter copies: entries 0..NI-1 secure, NI..2NI-1 non-secure
   logic [23:0] flt_q [0:2*NI-1];
   logic [31:0] su_q [0:2*NI-1];

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire sel_present = monitors_present_i || impl_identification_present_i;
   wire bwf_present = monitors_present_i && bandwidth_usage_present_i;
   wire suv_present = monitors_present_i && storage_usage_present_i;

   wire hit_sel = reg_addr_i == `MSFR_OFS_SELECTOR;
   wire hit_bwf = reg_addr_i == `MSFR_OFS_BW_FILTER;
   wire hit_suv = reg_addr_i == `MSFR_OFS_SU_VALUE;

   msfr_pkg::msfr_reg_e reg_sel;
   assign reg_sel = (hit_sel && sel_present) ? msfr_pkg::MSFR_REG_SEL :
                    (hit_bwf && bwf_present) ? msfr_pkg::MSFR_REG_BWF :
                    (hit_suv && suv_present) ? msfr_pkg::MSFR_REG_SUV :
                    msfr_pkg::MSFR_REG_NONE;

   // The banked selector chosen by the security state of the access
   wire [15:0] cur_sel = reg_ns_i ? sel_ns : sel_s;
   wire [`MSFR_IDX_W:0] cur_entry = {reg_ns_i, cur_sel[`MSFR_IDX_W-1:0]};

   // Out of range index: access is dropped and the error pulses
   wire bw_oob = cur_sel >= `MSFR_BW_INST_COUNT;
   wire su_oob = cur_sel >= `MSFR_SU_INST_COUNT;
   wire oob = (reg_sel == msfr_pkg::MSFR_REG_BWF && bw_oob)
              || (reg_sel == msfr_pkg::MSFR_REG_SUV && su_oob);

   wire acc = reg_req_i && ce_i;
   wire wr_sel = acc && reg_wr_i && reg_sel == msfr_pkg::MSFR_REG_SEL;
   wire wr_bwf = acc && reg_wr_i && reg_sel == msfr_pkg::MSFR_REG_BWF && !bw_oob;
   wire wr_suv = acc && reg_wr_i && reg_sel == msfr_pkg::MSFR_REG_SUV && !su_oob;

   wire [`MSFR_IDX_W:0] su_upd_entry = {su_upd_ns_i, su_upd_idx_i};

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      case (reg_sel)
         msfr_pkg::MSFR_REG_SEL: begin
            rd_mux = {16'h0000, cur_sel};
         end
         msfr_pkg::MSFR_REG_BWF: begin
            if (!bw_oob) begin
               rd_mux = {8'h00, flt_q[cur_entry]};
            end
         end
         msfr_pkg::MSFR_REG_SUV: begin
            if (!su_oob) begin
               rd_mux = su_q[cur_entry];
            end
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         reg_ack_o <= 1'b0;
         reg_rdata_o <= 32'h00000000;
         reg_oob_err_o <= 1'b0;
      end else if (ce_i) begin
         reg_ack_o <= reg_req_i;
         reg_rdata_o <= (reg_req_i && !reg_wr_i) ? rd_mux : 32'h00000000;
         reg_oob_err_o <= reg_req_i && oob;
      end
   end

   // ----------------------------------------
   // Banked selector
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sel_s <= `MSFR_RST_SELECTOR;
         sel_ns <= `MSFR_RST_SELECTOR;
      end else if (wr_sel) begin
         if (reg_ns_i) begin
            sel_ns <= reg_wdata_i[`MSFR_SEL_IDX_MSB:0];
         end else begin
            sel_s <= reg_wdata_i[`MSFR_SEL_IDX_MSB:0];
         end
      end
   end

   assign sel_s_o = sel_s;
   assign sel_ns_o = sel_ns;

   // ----------------------------------------
   // Per-instance filter and storage value
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2 * NI; g = g + 1) begin : g_inst
         localparam logic [`MSFR_IDX_W:0] ENTRY = (`MSFR_IDX_W + 1)'(g);
         wire flt_we = wr_bwf && cur_entry == ENTRY;
         wire su_hw = su_upd_i && ce_i && su_upd_entry == ENTRY;
         wire su_sw = wr_suv && cur_entry == ENTRY;

         always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
               flt_q[g] <= `MSFR_RST_FILTER;
            end else if (flt_we) begin
               flt_q[g] <= reg_wdata_i[`MSFR_FLT_GROUP_MSB:0];
            end
         end

         // A datapath update in the same cycle as a software write wins,
         // so a fresh occupancy figure is never lost.
         always_ff @(posedge core_clk_i) begin
            if (sys_rst_i) begin
               su_q[g] <= `MSFR_RST_SU_VALUE;
            end else if (su_hw) begin
               su_q[g] <= {su_upd_not_ready_i, su_upd_bytes_i};
            end else if (su_sw) begin
               su_q[g] <= reg_wdata_i;
            end
         end

         // Each copy counts only traffic of its own security state
         msfr_match u_match (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .ce_i(ce_i),
            .traffic_valid_i(traffic_valid_i),
            .state_hit_i(traffic_ns_i == (g >= NI)),
            .traffic_partition_i(traffic_partition_i),
            .traffic_group_i(traffic_group_i),
            .filter_partition_i(flt_q[g][`MSFR_FLT_PART_MSB:`MSFR_FLT_PART_LSB]),
            .filter_group_i(flt_q[g][`MSFR_FLT_GROUP_MSB:`MSFR_FLT_GROUP_LSB]),
            .group_match_enable_i(bw_ctl_i[g][`MSFR_CTL_GROUP_MATCH_BIT]),
            .partition_match_enable_i(bw_ctl_i[g][`MSFR_CTL_PART_MATCH_BIT]),
            .count_en_o(bw_count_en_o[g])
         );
      end
   endgenerate

endmodule : msfr_regs

/* File: msfr_cfg.svh */
// Offsets, field positions, reset values and sizes of the monitor select and filter registers
`ifndef MSFR_CFG_SVH
`define MSFR_CFG_SVH

// ----------------------------------------
// Register offsets within a feature page
// ----------------------------------------
`define MSFR_OFS_SELECTOR 12'h800
`define MSFR_OFS_BW_FILTER 12'h820
`define MSFR_OFS_SU_VALUE 12'h840

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSFR_SEL_IDX_MSB 15
`define MSFR_FLT_GROUP_MSB 23
`define MSFR_FLT_GROUP_LSB 16
`define MSFR_FLT_PART_MSB 15
`define MSFR_FLT_PART_LSB 0
`define MSFR_SU_NOT_READY_FLAG_BIT 31
`define MSFR_SU_VALUE_MSB 30
`define MSFR_CTL_GROUP_MATCH_BIT 17
`define MSFR_CTL_PART_MATCH_BIT 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MSFR_RST_SELECTOR 16'h0000
`define MSFR_RST_FILTER 24'h000000
`define MSFR_RST_SU_VALUE 32'h80000000

// ----------------------------------------
// Instance counts
// ----------------------------------------
`define MSFR_NUM_INST 4
`define MSFR_IDX_W 2
`define MSFR_BW_INST_COUNT 16'h0004
`define MSFR_SU_INST_COUNT 16'h0004

`endif

/* File: msfr_pkg.sv */
// Types shared by the monitor select and filter register files
package msfr_pkg;

   typedef logic [15:0] msfr_index_t;
   typedef logic [7:0] msfr_group_t;
   typedef logic [15:0] msfr_part_t;

   typedef enum logic [1:0] {
      MSFR_REG_NONE = 2'b00,
      MSFR_REG_SEL = 2'b01,
      MSFR_REG_BWF = 2'b10,
      MSFR_REG_SUV = 2'b11
   } msfr_reg_e;

endpackage : msfr_pkg

/* File: msfr_match.sv */
// One bandwidth monitor filter comparator with a registered count enable
`timescale 1ns/1ps
`include "msfr_cfg.svh"

module msfr_match (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic traffic_valid_i,
   input wire logic state_hit_i,
   input wire msfr_pkg::msfr_part_t traffic_partition_i,
   input wire msfr_pkg::msfr_group_t traffic_group_i,
   input wire msfr_pkg::msfr_part_t filter_partition_i,
   input wire msfr_pkg::msfr_group_t filter_group_i,
   input wire logic group_match_enable_i,
   input wire logic partition_match_enable_i,
   output logic count_en_o
);

   // ----------------------------------------
   // Match terms
   // ----------------------------------------
   wire group_ok = !group_match_enable_i || (traffic_group_i == filter_group_i);
   wire part_ok = !partition_match_enable_i
                  || (traffic_partition_i == filter_partition_i);
   wire next_count_en = traffic_valid_i && state_hit_i && group_ok && part_ok;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         count_en_o <= 1'b0;
      end else if (ce_i) begin
         count_en_o <= next_count_en;
      end
   end

endmodule : msfr_match

/* File: msfr_regs_chk.sv */
// Concurrent checks on the ports of the monitor select and filter registers
`timescale 1ns/1ps
`include "msfr_cfg.svh"

module msfr_regs_chk (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic monitors_present_i,
   input wire logic bandwidth_usage_present_i,
   input wire logic impl_identification_present_i,
   input wire logic reg_req_i,
   input wire logic reg_wr_i,
   input wire logic reg_ns_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_ack_o,
   input wire logic [31:0] reg_rdata_o,
   input wire logic reg_oob_err_o,
   input wire logic traffic_valid_i,
   input wire logic [2*`MSFR_NUM_INST-1:0] bw_count_en_o,
   input wire msfr_pkg::msfr_index_t sel_s_o,
   input wire msfr_pkg::msfr_index_t sel_ns_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // Index that steers this access, taken from the bank of its state
   wire msfr_pkg::msfr_index_t cur_sel = reg_ns_i ? sel_ns_o : sel_s_o;
   wire logic sel_here = monitors_present_i || impl_identification_present_i;
   // ----------------------------------------
   // Access steps
   // ----------------------------------------
   sequence take_s;
      reg_req_i && ce_i;
   endsequence
   sequence sel_wr_s;
      take_s ##0 (reg_wr_i && !reg_ns_i && reg_addr_i == 12'h800 && sel_here);
   endsequence
   ack_follows_a: assert property (take_s |=> reg_ack_o)
      else $error("no ack after request");
   ack_idle_a: assert property (ce_i && !reg_req_i |=> !reg_ack_o)
      else $error("ack without request");
   oob_flag_a: assert property (take_s ##0 (reg_addr_i == 12'h820 &&
      cur_sel >= 16'h0004 && monitors_present_i && bandwidth_usage_present_i) |=> reg_oob_err_o)
      else $error("missing out-of-bounds flag");
   sel_no_err_a: assert property (take_s ##0 (reg_addr_i == 12'h800) |=> !reg_oob_err_o)
      else $error("error flag on selector access");
   sel_write_a: assert property (sel_wr_s |=> {16'h0000, sel_s_o} ==
      ($past(reg_wdata_i) & 32'h0000FFFF)) else $error("secure selector not written");
   sel_absent_a: assert property (take_s ##0 (reg_wr_i && !sel_here) |=>
      $stable(sel_s_o) && $stable(sel_ns_o)) else $error("absent selector changed");
   sel_read_a: assert property (take_s ##0 (!reg_wr_i && reg_ns_i &&
      reg_addr_i == 12'h800 && sel_here) |=> reg_rdata_o == {16'h0000, $past(sel_ns_o)})
      else $error("selector read mismatch");
   flt_absent_a: assert property (take_s ##0 (!reg_wr_i && reg_addr_i == 12'h820 &&
      !(monitors_present_i && bandwidth_usage_present_i)) |=> reg_rdata_o == 32'h00000000)
      else $error("absent filter read nonzero");
   count_idle_a: assert property (ce_i && !traffic_valid_i |=> !(|bw_count_en_o))
      else $error("count enable without traffic");
endmodule : msfr_regs_chk

bind msfr_regs msfr_regs_chk u_chk (.*);

/* File: msfr_regs_tb_top.sv */
// Self-checking testbench for the monitor select and filter registers
`timescale 1ns/1ps
`include "msfr_cfg.svh"

module msfr_regs_tb_top;
   logic core_clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic ce_i = 1'h1, monitors_present_i = 1'h1, bandwidth_usage_present_i = 1'h1;
   logic storage_usage_present_i = 1'h1, impl_identification_present_i = 1'h1;
   logic reg_req_i = 1'h0, reg_wr_i = 1'h0, reg_ns_i = 1'h0, traffic_valid_i = 1'h0;
   logic traffic_ns_i = 1'h0, su_upd_i = 1'h0, su_upd_ns_i = 1'h0, su_upd_not_ready_i = 1'h0;
   logic [11:0] reg_addr_i = 12'h000;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic [31:0] bw_ctl_i [0:2*`MSFR_NUM_INST-1] = '{default: 32'h0};
   msfr_pkg::msfr_part_t traffic_partition_i = 16'h0;
   msfr_pkg::msfr_group_t traffic_group_i = 8'h0;
   logic [`MSFR_IDX_W-1:0] su_upd_idx_i = 2'h0;
   logic [30:0] su_upd_bytes_i = 31'h0;
   logic reg_ack_o, reg_oob_err_o, err_seen;
   logic [2*`MSFR_NUM_INST-1:0] bw_count_en_o;
   msfr_pkg::msfr_index_t sel_s_o, sel_ns_o;
   int fail_count = 0, cmp_count = 0;
   msfr_regs DUT (.*);
   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task acc(input logic w, input logic n, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      #1;
      reg_req_i = 1'h1;
      reg_wr_i = w;
      reg_ns_i = n;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge core_clk_i);
      #1;
      reg_req_i = 1'h0;
      chk(reg_ack_o, 32'h1);
      err_seen = reg_oob_err_o;
   endtask : acc
   task rd(input logic n, input logic [11:0] a, input logic [31:0] exp);
      acc(1'h0, n, a, 32'h0);
      chk(reg_rdata_o, exp);
   endtask : rd
   task trf(input logic n, input logic [15:0] p, input logic [7:0] g, input logic [2:0] b,
      input logic e);
      @(posedge core_clk_i);
      #1;
      traffic_valid_i = 1'h1;
      traffic_ns_i = n;
      traffic_partition_i = p;
      traffic_group_i = g;
      @(posedge core_clk_i);
      #1;
      traffic_valid_i = 1'h0;
      chk(bw_count_en_o[b], e);
   endtask : trf
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_filter;
      rd(1'h0, 12'h840, 32'h80000000);
      acc(1'h1, 1'h0, 12'h800, 32'hFFFF0002);
      rd(1'h0, 12'h800, 32'h00000002);
      acc(1'h1, 1'h0, 12'h820, 32'hFFAB1234);
      acc(1'h1, 1'h1, 12'h800, 32'h00000001);
      acc(1'h1, 1'h1, 12'h820, 32'h00CD5678);
      chk(sel_s_o, 32'h2);
      rd(1'h0, 12'h820, 32'h00AB1234);
      rd(1'h1, 12'h820, 32'h00CD5678);
      acc(1'h1, 1'h0, 12'h800, 32'h00000003);
      rd(1'h0, 12'h820, 32'h00000000);
      $display("filter test done");
   endtask : t_filter
   task t_match;
      bw_ctl_i[2] = 32'h00030000;
      bw_ctl_i[5] = 32'h00030000;
      trf(1'h0, 16'h1234, 8'hAB, 3'h2, 1'h1);
      trf(1'h0, 16'h1234, 8'hAC, 3'h2, 1'h0);
      trf(1'h0, 16'h1235, 8'hAB, 3'h2, 1'h0);
      trf(1'h1, 16'h5678, 8'hCD, 3'h5, 1'h1);
      trf(1'h0, 16'h5678, 8'hCD, 3'h5, 1'h0);
      bw_ctl_i[2] = 32'h00010000;
      trf(1'h0, 16'h1234, 8'h00, 3'h2, 1'h1);
      bw_ctl_i[2] = 32'h00020000;
      trf(1'h0, 16'h0000, 8'hAB, 3'h2, 1'h1);
      $display("match test done");
   endtask : t_match
   task t_bounds;
      acc(1'h1, 1'h0, 12'h800, 32'h00000004);
      rd(1'h0, 12'h820, 32'h00000000);
      chk(err_seen, 32'h1);
      acc(1'h1, 1'h0, 12'h800, 32'h00000003);
      rd(1'h0, 12'h820, 32'h00000000);
      chk(err_seen, 32'h0);
      $display("bounds test done");
   endtask : t_bounds
   task t_storage;
      @(posedge core_clk_i);
      #1;
      su_upd_i = 1'h1;
      su_upd_ns_i = 1'h1;
      su_upd_idx_i = 2'h1;
      su_upd_bytes_i = 31'h00012345;
      @(posedge core_clk_i);
      #1;
      su_upd_i = 1'h0;
      rd(1'h1, 12'h840, 32'h00012345);
      rd(1'h0, 12'h840, 32'h80000000);
      $display("storage test done");
   endtask : t_storage
   task t_absent;
      bandwidth_usage_present_i = 1'h0;
      acc(1'h1, 1'h0, 12'h820, 32'h00FFFFFF);
      chk(err_seen, 32'h0);
      bandwidth_usage_present_i = 1'h1;
      rd(1'h0, 12'h820, 32'h00000000);
      monitors_present_i = 1'h0;
      impl_identification_present_i = 1'h0;
      acc(1'h1, 1'h0, 12'h800, 32'h00000001);
      rd(1'h0, 12'h800, 32'h00000000);
      impl_identification_present_i = 1'h1;
      rd(1'h0, 12'h800, 32'h00000003);
      $display("absent test done");
   endtask : t_absent
   // A request while the clock enable is low must leave no trace
   task t_freeze;
      @(posedge core_clk_i);
      #1;
      ce_i = 1'h0;
      reg_req_i = 1'h1;
      reg_wr_i = 1'h1;
      reg_ns_i = 1'h0;
      reg_addr_i = 12'h800;
      reg_wdata_i = 32'h00000007;
      @(posedge core_clk_i);
      #1;
      reg_req_i = 1'h0;
      ce_i = 1'h1;
      chk(sel_s_o, 32'h3);
      chk(reg_ack_o, 32'h0);
      $display("freeze test done");
   endtask : t_freeze
   task results;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   initial begin
      #20000;
      fail_count++;
      results();
   end
   initial begin
      repeat (2) @(posedge core_clk_i);
      #1;
      sys_rst_i = 1'h0;
      t_filter();
      t_match();
      t_bounds();
      t_storage();
      t_absent();
      t_freeze();
      results();
   end
endmodule : msfr_regs_tb_top
